// ### design/lcdr_map.svh
`ifndef LCDR_MAP_SVH
`define LCDR_MAP_SVH

// Register offsets
`define LCDR_TEST_REGISTER 6'h00
`define LCDR_IDENTITY_VERSION 6'h01
`define LCDR_INPUT_FORMAT_CONTROL 6'h02
`define LCDR_POWER_OUTPUT_CONTROL 6'h03
`define LCDR_PUMP_REVERSE_CONTROL 6'h04
`define LCDR_HORIZONTAL_START 6'h05
`define LCDR_VERTICAL_START 6'h06
`define LCDR_SHIFT_CLOCK_HIGH_WIDTH 6'h07
`define LCDR_ENABLE_LOW_WIDTH 6'h0a
`define LCDR_RED_CONTRAST_GAIN 6'h0b
`define LCDR_BLUE_CONTRAST_GAIN 6'h0d
`define LCDR_RED_BRIGHTNESS_OFFSET 6'h0e
`define LCDR_BLUE_BRIGHTNESS_OFFSET 6'h10
`define LCDR_GAMMA_HIGH_BITS_A 6'h11
`define LCDR_GAMMA_HIGH_BITS_B 6'h12
`define LCDR_GAMMA_HIGH_BITS_C 6'h13
`define LCDR_GAMMA_POINT0_LOW 6'h14
`define LCDR_LAST_REG 6'h14
`define LCDR_NUM_REGS 21

// Reset values
`define LCDR_RST_TEST 8'h00
`define LCDR_RST_FORMAT 8'h07
`define LCDR_RST_POWER 8'h5f
`define LCDR_RST_PUMP 8'h17
`define LCDR_RST_HSTART 8'h20
`define LCDR_RST_VSTART 8'h08
`define LCDR_RST_TIMING 8'h20
`define LCDR_RST_GAIN 8'h20
`define LCDR_RST_OFFSET 8'h10
`define LCDR_RST_GAMMA_A 8'h00
`define LCDR_RST_GAMMA_B 8'h5b
`define LCDR_RST_GAMMA_C 8'hff
`define LCDR_RST_GAMMA_LOW 8'h00

// Writable bit masks
`define LCDR_MASK_FULL 8'hff
`define LCDR_MASK_PUMP 8'h3f
`define LCDR_MASK_SIX 8'h3f
`define LCDR_MASK_FOUR 8'h0f

// Field positions
`define LCDR_FMT_LATCH_BIT 3
`define LCDR_FMT_RES_HI 2
`define LCDR_PWR_SOFT_BIT 7
`define LCDR_PWR_PRECHARGE_BIT 6
`define LCDR_PWR_DRIVE_HI 5
`define LCDR_PWR_DRIVE_LO 4
`define LCDR_PWR_PWM_BIT 3
`define LCDR_PWR_VGL_BIT 2
`define LCDR_PWR_CPCLK_BIT 1
`define LCDR_PWR_NORMAL_BIT 0

// Serial frame layout
`define LCDR_FRAME_ADDR_BITS 6
`define LCDR_FRAME_RW_POS 5'h06
`define LCDR_FRAME_DATA_POS 5'h08
`define LCDR_FRAME_LAST 5'h0f
`define LCDR_FRAME_BITS 5'h10

`endif

// ### design/lcdr_pkg.sv
package lcdr_pkg;

  typedef logic [7:0] lcdr_byte_t;

  typedef struct packed {
    lcdr_byte_t [20:0] regs;
    logic [1:0] cs_s;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d;
    logic [2:0] res_a;
    logic [2:0] res_b;
    logic [1:0] stby_s;
    logic [4:0] cnt;
    logic [5:0] addr;
    logic rw;
    logic [7:0] shift;
    logic sda_o;
    logic sda_oe;
    logic [2:0] res_eff;
    logic standby;
    logic latch_rise;
    logic pwm_on;
    logic precharge_on;
    logic [1:0] drive;
    logic vgl_on;
    logic cpclk_on;
    logic cpclk1_high;
    logic cpclk_low;
  } lcdr_state_t;

endpackage

// ### design/lcdr_regs.sv
`timescale 1ns/100ps
`include "lcdr_map.svh"

module lcdr_regs
  import lcdr_pkg::*;
#(
  parameter logic [3:0] IDENTITY_VERSION = 4'h3,  // Arbitrary value
  parameter logic [3:0] CHIP_REV = 4'h5  // Arbitrary value
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic spi_clk,
  input wire logic serial_chip_select_n,
  input wire logic spi_data_in,
  output logic spi_data_out,
  output logic spi_data_oe,
  input wire logic [2:0] resolution_pins,
  input wire logic standby_pin_n,
  output logic [2:0] resolution,
  output logic standby,
  output logic pixel_latch_rising,
  output logic pwm_enable,
  output logic pre_charge_enable,
  output logic [1:0] drive_strength,
  output logic gate_low_voltage_pump_enable,
  output logic charge_pump_clock_out_enable,
  output logic charge_pump_clock1_high,
  output logic charge_pump_clock_low,
  output logic [167:0] config_image
);

  lcdr_state_t state_reg;
  lcdr_state_t state_next;

  // Bits that software may change per register
  function automatic lcdr_byte_t write_mask(input logic [5:0] a);
    lcdr_byte_t m;
    m = 8'h00;
    if (a == `LCDR_IDENTITY_VERSION) begin
      m = 8'h00;
    end else if (a == `LCDR_PUMP_REVERSE_CONTROL) begin
      m = `LCDR_MASK_PUMP;
    end else if (a == `LCDR_VERTICAL_START) begin
      m = `LCDR_MASK_FOUR;
    end else if (a >= `LCDR_HORIZONTAL_START && a <= `LCDR_BLUE_BRIGHTNESS_OFFSET) begin
      m = `LCDR_MASK_SIX;
    end else if (a <= `LCDR_LAST_REG) begin
      m = `LCDR_MASK_FULL;
    end
    return m;
  endfunction

  // Reset value per register
  function automatic lcdr_byte_t reset_value(input int i);
    lcdr_byte_t v;
    v = 8'h00;
    if (i == int'(`LCDR_INPUT_FORMAT_CONTROL)) begin
      v = `LCDR_RST_FORMAT;
    end else if (i == int'(`LCDR_POWER_OUTPUT_CONTROL)) begin
      v = `LCDR_RST_POWER;
    end else if (i == int'(`LCDR_PUMP_REVERSE_CONTROL)) begin
      v = `LCDR_RST_PUMP;
    end else if (i == int'(`LCDR_HORIZONTAL_START)) begin
      v = `LCDR_RST_HSTART;
    end else if (i == int'(`LCDR_VERTICAL_START)) begin
      v = `LCDR_RST_VSTART;
    end else if (i >= int'(`LCDR_SHIFT_CLOCK_HIGH_WIDTH) && i <= int'(`LCDR_ENABLE_LOW_WIDTH)) begin
      v = `LCDR_RST_TIMING;
    end else if (i >= int'(`LCDR_RED_CONTRAST_GAIN) && i <= int'(`LCDR_BLUE_CONTRAST_GAIN)) begin
      v = `LCDR_RST_GAIN;
    end else if (i >= int'(`LCDR_RED_BRIGHTNESS_OFFSET) && i <= int'(`LCDR_BLUE_BRIGHTNESS_OFFSET)) begin
      v = `LCDR_RST_OFFSET;
    end else if (i == int'(`LCDR_GAMMA_HIGH_BITS_A)) begin
      v = `LCDR_RST_GAMMA_A;
    end else if (i == int'(`LCDR_GAMMA_HIGH_BITS_B)) begin
      v = `LCDR_RST_GAMMA_B;
    end else if (i == int'(`LCDR_GAMMA_HIGH_BITS_C)) begin
      v = `LCDR_RST_GAMMA_C;
    end else if (i == int'(`LCDR_GAMMA_POINT0_LOW)) begin
      v = `LCDR_RST_GAMMA_LOW;
    end else begin
      v = `LCDR_RST_TEST;
    end
    return v;
  endfunction

  // Reset image of the whole state
  function automatic lcdr_state_t reset_state();
    lcdr_state_t s;
    s = '0;
    for (int i = 0; i < `LCDR_NUM_REGS; i++) begin
      s.regs[i] = reset_value(i);
    end
    s.regs[`LCDR_IDENTITY_VERSION] = 8'h00;
    s.cs_s = 2'h3;
    s.stby_s = 2'h3;
    s.res_a = 3'h7;
    s.res_b = 3'h7;
    s.res_eff = 3'h7;
    s.pwm_on = 1'b1;
    s.precharge_on = 1'b1;
    s.drive = 2'h1;
    s.vgl_on = 1'b1;
    s.cpclk_on = 1'b1;
    return s;
  endfunction

  // Constant reset image, so the async reset branch loads a constant only
  localparam lcdr_state_t RESET_STATE = reset_state();

  // Read data for a frame address
  function automatic lcdr_byte_t read_value(input lcdr_state_t s, input logic [5:0] a);
    lcdr_byte_t v;
    v = 8'h00;
    if (a == `LCDR_IDENTITY_VERSION) begin
      v = {IDENTITY_VERSION, CHIP_REV};
    end else if (a <= `LCDR_LAST_REG) begin
      v = s.regs[a[4:0]] & write_mask(a);
    end
    return v;
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic cs_active;
  lcdr_byte_t rd_byte;
  lcdr_byte_t pwr;
  lcdr_byte_t fmt;
  logic soft_sel;
  logic stby_now;

  // Serial port engine and derived controls
  always_comb begin
    state_next = state_reg;
    // Two-stage synchronisers, first stage read only by second
    state_next.cs_s = {state_reg.cs_s[0], serial_chip_select_n};
    state_next.scl_s = {state_reg.scl_s[0], spi_clk};
    state_next.sda_s = {state_reg.sda_s[0], spi_data_in};
    state_next.res_a = resolution_pins;
    state_next.res_b = state_reg.res_a;
    state_next.stby_s = {state_reg.stby_s[0], standby_pin_n};
    state_next.scl_d = state_reg.scl_s[1];
    scl_rise = state_reg.scl_s[1] & ~state_reg.scl_d;
    scl_fall = ~state_reg.scl_s[1] & state_reg.scl_d;
    cs_active = ~state_reg.cs_s[1];
    rd_byte = read_value(state_reg, state_reg.addr);

    // Frame: 6 address bits, read flag, turnaround, 8 data bits, MSB first
    if (!cs_active) begin
      state_next.cnt = 5'h00;
      state_next.rw = 1'b0;
      state_next.sda_oe = 1'b0;
      state_next.sda_o = 1'b0;
    end else begin
      if (scl_rise && state_reg.cnt < `LCDR_FRAME_BITS) begin
        state_next.cnt = state_reg.cnt + 5'h01;
        if (state_reg.cnt < `LCDR_FRAME_RW_POS) begin
          state_next.addr = {state_reg.addr[4:0], state_reg.sda_s[1]};
        end else if (state_reg.cnt == `LCDR_FRAME_RW_POS) begin
          state_next.rw = state_reg.sda_s[1];
        end else if (state_reg.cnt >= `LCDR_FRAME_DATA_POS) begin
          state_next.shift = {state_reg.shift[6:0], state_reg.sda_s[1]};
        end
        // Host configuration writes land on the last data bit
        if (state_reg.cnt == `LCDR_FRAME_LAST && !state_reg.rw && state_reg.addr <= `LCDR_LAST_REG) begin
          state_next.regs[state_reg.addr[4:0]] =
            {state_reg.shift[6:0], state_reg.sda_s[1]} & write_mask(state_reg.addr);
        end
      end
      // Read data shifts out after each falling edge of the data phase
      if (scl_fall && state_reg.rw) begin
        if (state_reg.cnt >= `LCDR_FRAME_DATA_POS && state_reg.cnt <= `LCDR_FRAME_LAST) begin
          state_next.sda_oe = 1'b1;
          state_next.sda_o = rd_byte[3'(`LCDR_FRAME_LAST - state_reg.cnt)];
        end else begin
          state_next.sda_oe = 1'b0;
        end
      end
    end

    // Pin or register source for resolution and standby
    pwr = state_reg.regs[`LCDR_POWER_OUTPUT_CONTROL];
    fmt = state_reg.regs[`LCDR_INPUT_FORMAT_CONTROL];
    soft_sel = pwr[`LCDR_PWR_SOFT_BIT];
    if (soft_sel) begin
      state_next.res_eff = fmt[`LCDR_FMT_RES_HI:0];
      stby_now = ~pwr[`LCDR_PWR_NORMAL_BIT];
    end else begin
      state_next.res_eff = state_reg.res_b;
      stby_now = ~state_reg.stby_s[1];
    end
    state_next.standby = stby_now;
    state_next.latch_rise = fmt[`LCDR_FMT_LATCH_BIT];
    state_next.precharge_on = pwr[`LCDR_PWR_PRECHARGE_BIT];
    state_next.drive = pwr[`LCDR_PWR_DRIVE_HI:`LCDR_PWR_DRIVE_LO];

    // Standby overrides PWM and pump outputs
    state_next.pwm_on = pwr[`LCDR_PWR_PWM_BIT] & ~stby_now;
    state_next.vgl_on = pwr[`LCDR_PWR_VGL_BIT] & ~stby_now;
    state_next.cpclk_on = pwr[`LCDR_PWR_CPCLK_BIT] & ~stby_now;
    state_next.cpclk1_high = stby_now;
    state_next.cpclk_low = stby_now;
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state flops
  assign spi_data_out = state_reg.sda_o;
  assign spi_data_oe = state_reg.sda_oe;
  assign resolution = state_reg.res_eff;
  assign standby = state_reg.standby;
  assign pixel_latch_rising = state_reg.latch_rise;
  assign pwm_enable = state_reg.pwm_on;
  assign pre_charge_enable = state_reg.precharge_on;
  assign drive_strength = state_reg.drive;
  assign gate_low_voltage_pump_enable = state_reg.vgl_on;
  assign charge_pump_clock_out_enable = state_reg.cpclk_on;
  assign charge_pump_clock1_high = state_reg.cpclk1_high;
  assign charge_pump_clock_low = state_reg.cpclk_low;
  assign config_image = state_reg.regs;

endmodule

// ### testbench/lcdr_regs_sva.sv
`timescale 1ns/100ps
// Port-level checks of the serial register bank
module lcdr_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic standby_pin_n,
  input wire logic serial_chip_select_n,
  input wire logic spi_data_oe,
  input wire logic [2:0] resolution,
  input wire logic standby,
  input wire logic pixel_latch_rising,
  input wire logic pwm_enable,
  input wire logic pre_charge_enable,
  input wire logic [1:0] drive_strength,
  input wire logic gate_low_voltage_pump_enable,
  input wire logic charge_pump_clock_out_enable,
  input wire logic charge_pump_clock1_high,
  input wire logic charge_pump_clock_low,
  input wire logic [167:0] config_image
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Standby shuts PWM and both pumps, and parks the pump clocks
  a_stby_off:
    assert property (standby [*2] |-> !pwm_enable && !gate_low_voltage_pump_enable && !charge_pump_clock_out_enable)
    else $error("pwm or pump still on in standby");
  a_stby_park:
    assert property (standby [*2] |-> charge_pump_clock1_high && charge_pump_clock_low)
    else $error("pump clocks not parked in standby");
  a_run_unparked:
    assert property (!standby [*2] |-> !charge_pump_clock1_high && !charge_pump_clock_low)
    else $error("pump clocks parked while running");
  // Control outputs follow the stored fields one cycle later
  a_latch_edge:
    assert property (1'b1 |=> pixel_latch_rising == $past(config_image[19]))
    else $error("latch edge output does not follow its bit");
  a_drive_follow:
    assert property (1'b1 |=> {pre_charge_enable, drive_strength} == $past(config_image[30:28]))
    else $error("pre-charge or drive output does not follow its field");
  a_soft_source:
    assert property (config_image[31] |=> resolution == $past(config_image[18:16])
      && standby == !$past(config_image[24]))
    else $error("software source not followed");
  a_pin_standby:
    assert property ((!config_image[31] && !standby_pin_n) [*4] |-> standby)
    else $error("standby pin not followed");
  a_oe_idle:
    assert property (serial_chip_select_n [*6] |-> !spi_data_oe)
    else $error("data line driven outside a frame");
  a_unused_zero:
    assert property (config_image[39:38] == 2'b00 && config_image[47:46] == 2'b00 && config_image[55:52] == 4'h0)
    else $error("unassigned bits stored");
endmodule

bind lcdr_regs lcdr_chk chk (.clk, .nrst, .standby_pin_n, .serial_chip_select_n, .spi_data_oe, .resolution,
  .standby, .pixel_latch_rising, .pwm_enable, .pre_charge_enable, .drive_strength, .gate_low_voltage_pump_enable,
  .charge_pump_clock_out_enable, .charge_pump_clock1_high, .charge_pump_clock_low, .config_image);

// ### testbench/lcdr_host.sv
`timescale 1ns/100ps
// Host serial controller: 16-bit frames, MSB first, 400 ns half periods
module lcdr_host (
  input wire logic clk,
  output logic spi_clk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic bit_q = 1'b0;
  logic idle_q = 1'b0;
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
  end
  // Outside frames the data line toggles so no stale bit survives
  always @(posedge clk) idle_q <= ~idle_q;
  assign sdi = cs_n ? idle_q : bit_q;
  // One frame: address, read flag, turnaround, data byte
  task automatic xfer(input logic [5:0] a, input logic rd, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {a, rd, 1'b0, d};
    q = 8'h00;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      bit_q <= f[i];
      repeat (4) @(posedge clk);
      spi_clk <= 1'b1;
      repeat (2) @(posedge clk);
      if (i < 8) q[i] = sdo_oe ? sdo : 1'bx;
      repeat (2) @(posedge clk);
      spi_clk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import lcdr_pkg::*;
  localparam logic [3:0] ID = 4'h9;  // Arbitrary value
  localparam logic [3:0] REV = 4'h2;  // Arbitrary value
  logic clk, nrst, sck, csn, sdi, sdo, oe, stn, stby, lat, pwm, pre, gate_low_voltage_pump, cpe, cp1, cpl;
  logic [2:0] pins, res;
  logic [1:0] drv;
  int fails = 0;
  int samples_checked = 0;
  int seed = 61376;
  lcdr_byte_t q;
  lcdr_byte_t sh [22];
  lcdr_host host (.clk(clk), .spi_clk(sck), .cs_n(csn), .sdi(sdi), .sdo(sdo), .sdo_oe(oe));
  lcdr_regs #(.IDENTITY_VERSION(ID), .CHIP_REV(REV)) dut (.clk(clk), .nrst(nrst), .spi_clk(sck),
    .serial_chip_select_n(csn), .spi_data_in(sdi), .spi_data_out(sdo), .spi_data_oe(oe),
    .resolution_pins(pins), .standby_pin_n(stn), .resolution(res), .standby(stby),
    .pixel_latch_rising(lat), .pwm_enable(pwm), .pre_charge_enable(pre), .drive_strength(drv),
    .gate_low_voltage_pump_enable(gate_low_voltage_pump), .charge_pump_clock_out_enable(cpe),
    .charge_pump_clock1_high(cp1), .charge_pump_clock_low(cpl), .config_image());
  // Writable bits of each address
  function automatic lcdr_byte_t mask_of(input int a);
    case (a)
      0, 2, 3, 17, 18, 19, 20: return 8'hff;
      6: return 8'h0f;
      1, 21: return 8'h00;
      default: return 8'h3f;
    endcase
  endfunction
  // Value after reset of each address
  function automatic lcdr_byte_t rst_of(input int a);
    case (a)
      1: return {ID, REV};
      2: return 8'h07;
      3: return 8'h5f;
      4: return 8'h17;
      6: return 8'h08;
      14, 15, 16: return 8'h10;
      18: return 8'h5b;
      19: return 8'hff;
      0, 17, 20, 21: return 8'h00;
      default: return 8'h20;
    endcase
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input int a, input lcdr_byte_t v);
    host.xfer(6'(a), 1'b0, v, q);
    if (a != 1) sh[a] = v & mask_of(a);
  endtask
  task automatic rdc(input int a);
    host.xfer(6'(a), 1'b1, 8'h00, q);
    check(q, sh[a], "readback");
  endtask
  task automatic close_out;
    $display("Checks made: %0d, mismatches: %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Watchdog at about 1.8 times the expected run length (202 frames of 139 clocks, about 2.81 ms)
  initial begin
    #5000000;
    fails++;
    close_out();
  end
  initial begin
    nrst = 1'b0;
    pins = 3'h5;
    stn = 1'b1;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    // Reset values, identity and an unmapped address
    for (int a = 0; a < 22; a++) sh[a] = rst_of(a);
    for (int a = 0; a < 22; a++) rdc(a);
    // All ones, all zeros, then random data everywhere
    for (int n = 0; n < 4; n++) begin
      for (int a = 0; a < 22; a++) wr(a, n == 0 ? 8'hff : n == 1 ? 8'h00 : 8'($random(seed)));
      for (int a = 0; a < 22; a++) rdc(a);
      check({4'h0, lat, pre, drv}, {4'h0, sh[2][3], sh[3][6], sh[3][5:4]}, "controls");
    end
    // Software source: standby, then running
    wr(2, 8'h0d);
    wr(3, 8'hae);
    check({lat, stby, pwm, pre, gate_low_voltage_pump, cpe, cp1, cpl}, 8'hc3, "soft standby");
    check({3'h0, res, drv}, 8'h16, "soft resolution");
    wr(3, 8'hef);
    check({lat, stby, pwm, pre, gate_low_voltage_pump, cpe, cp1, cpl}, 8'hbc, "soft run");
    // Hardware source: pins decide
    wr(3, 8'h5e);
    pins <= 3'($random(seed));
    repeat (8) @(posedge clk);
    check({5'h0, res}, {5'h0, pins}, "pin resolution");
    stn <= 1'b0;
    repeat (8) @(posedge clk);
    check({lat, stby, pwm, pre, gate_low_voltage_pump, cpe, cp1, cpl}, 8'hd3, "pin standby");
    stn <= 1'b1;
    close_out();
  end
endmodule
